/* rtl/rtcirq_top.sv */
// Interrupt flags, enables, square-wave output and general memory of
// the real-time clock, reached over an AXI4-Lite slave.
// Assumes alarm and update-done events arrive as one-cycle pulses in clk.
`timescale 1ns/1ps
`default_nettype none
`include "rtcirq_regs.svh"

module rtcirq_top
    import rtcirq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        alarm_event,
    input  wire logic        update_done_event,
    output logic             irq_n,
    output logic             square_wave_out,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    rtcirq_state_type wr_st_r;
    rtcirq_state_type rd_st_r;
    logic [11:0]      aw_addr_r;
    logic             aw_got_r;
    logic [31:0]      w_data_r;
    logic [3:0]       w_strb_r;
    logic             w_got_r;
    logic             awready_r;
    logic             wready_r;
    logic             bvalid_r;
    logic [1:0]       bresp_r;
    logic             arready_r;
    logic             rvalid_r;
    logic [1:0]       rresp_r;
    logic [31:0]      rdata_r;

    logic [2:0]       osc_ctrl_r;
    logic [3:0]       rate_sel_r;
    logic [2:0]       irq_enable_r;
    logic [2:0]       irq_enable_nxt;
    logic             square_wave_enable_r;
    logic [2:0]       flags_r;
    logic [2:0]       flags_nxt;
    logic [2:0]       events;
    logic             irq_n_r;
    logic             sqw_r;
    logic [7:0]       nvram_mem [0:`RTCIRQ_MEM_BYTES-1];

    logic             aw_fire;
    logic             w_fire;
    logic             b_fire;
    logic             ar_fire;
    logic             r_fire;
    logic             wr_do;
    logic             wr_lane;
    rtcirq_sel_type   wr_sel;
    rtcirq_sel_type   rd_sel;
    logic             flags_clear;
    logic [31:0]      rd_word;
    logic             tap_level;
    logic             tap_rise;

    // Address decode shared by the write and read paths
    function automatic rtcirq_sel_type rtcirq_decode(input logic [11:0] a);
        if (a == `RTCIRQ_OFF_CTRL_A) begin
            return RTCIRQ_SEL_CTRL_A;
        end else if (a == `RTCIRQ_OFF_CTRL_B) begin
            return RTCIRQ_SEL_CTRL_B;
        end else if (a == `RTCIRQ_OFF_FLAGS) begin
            return RTCIRQ_SEL_FLAGS;
        end else if (a >= `RTCIRQ_OFF_MEM && a <= `RTCIRQ_OFF_MEM_END &&
                     a[1:0] == 2'h0) begin
            return RTCIRQ_SEL_MEM;
        end else begin
            return RTCIRQ_SEL_NONE;
        end
    endfunction

    function automatic logic [6:0] rtcirq_mem_idx(input logic [11:0] a);
        // The window straddles a 512-byte boundary; 7-bit wrap gives 0..113
        return a[`RTCIRQ_MEM_IDX_HI:`RTCIRQ_MEM_IDX_LO] - `RTCIRQ_MEM_BASE_IDX;
    endfunction

    assign aw_fire = s_axi_awvalid && awready_r;
    assign w_fire  = s_axi_wvalid && wready_r;
    assign b_fire  = bvalid_r && s_axi_bready;
    assign ar_fire = s_axi_arvalid && arready_r;
    assign r_fire  = rvalid_r && s_axi_rready;
    assign wr_do   = (wr_st_r == RTCIRQ_ST_IDLE) && aw_got_r && w_got_r;
    assign wr_lane = w_strb_r[0];
    assign wr_sel  = rtcirq_decode(aw_addr_r);
    assign rd_sel  = rtcirq_decode(s_axi_araddr);
    assign flags_clear = ar_fire && (rd_sel == RTCIRQ_SEL_FLAGS);

    // Write address and data are taken in either order, then one response
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_addr_r <= 12'h000;
            aw_got_r  <= 1'b0;
            awready_r <= 1'b0;
        end else if (aw_fire) begin
            aw_addr_r <= s_axi_awaddr;
            aw_got_r  <= 1'b1;
            awready_r <= 1'b0;
        end else if (wr_do) begin
            aw_got_r <= 1'b0;
        end else if (wr_st_r == RTCIRQ_ST_IDLE && !aw_got_r) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            w_got_r  <= 1'b0;
            wready_r <= 1'b0;
        end else if (w_fire) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            w_got_r  <= 1'b1;
            wready_r <= 1'b0;
        end else if (wr_do) begin
            w_got_r <= 1'b0;
        end else if (wr_st_r == RTCIRQ_ST_IDLE && !w_got_r) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_st_r  <= RTCIRQ_ST_IDLE;
            bvalid_r <= 1'b0;
            bresp_r  <= `RTCIRQ_RESP_OKAY;
        end else begin
            case (wr_st_r)
                RTCIRQ_ST_IDLE: begin
                    if (wr_do) begin
                        wr_st_r  <= RTCIRQ_ST_RESP;
                        bvalid_r <= 1'b1;
                        bresp_r  <= (wr_sel == RTCIRQ_SEL_NONE) ?
                                    `RTCIRQ_RESP_SLVERR : `RTCIRQ_RESP_OKAY;
                    end
                end
                RTCIRQ_ST_RESP: begin
                    if (b_fire) begin
                        wr_st_r  <= RTCIRQ_ST_IDLE;
                        bvalid_r <= 1'b0;
                    end
                end
                default: begin
                    wr_st_r  <= RTCIRQ_ST_IDLE;
                    bvalid_r <= 1'b0;
                end
            endcase
        end
    end

    // Oscillator and rate control; reset leaves the oscillator stopped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            osc_ctrl_r <= `RTCIRQ_RST_OSC;
            rate_sel_r <= `RTCIRQ_RST_RATE;
        end else if (wr_do && wr_lane && wr_sel == RTCIRQ_SEL_CTRL_A) begin
            osc_ctrl_r <= w_data_r[`RTCIRQ_A_OSC_HI:`RTCIRQ_A_OSC_LO];
            rate_sel_r <= w_data_r[`RTCIRQ_A_RATE_HI:`RTCIRQ_A_RATE_LO];
        end
    end

    always_comb begin
        irq_enable_nxt = irq_enable_r;
        if (wr_do && wr_lane && wr_sel == RTCIRQ_SEL_CTRL_B) begin
            irq_enable_nxt = w_data_r[`RTCIRQ_B_EN_HI:`RTCIRQ_B_EN_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_enable_r         <= `RTCIRQ_RST_EN;
            square_wave_enable_r <= 1'b0;
        end else begin
            irq_enable_r <= irq_enable_nxt;
            if (wr_do && wr_lane && wr_sel == RTCIRQ_SEL_CTRL_B) begin
                square_wave_enable_r <= w_data_r[`RTCIRQ_B_SQUARE_WAVE_ENABLE];
            end
        end
    end

    // Alarm matching and update sequencing sit outside this block
    assign events[`RTCIRQ_SRC_PERIODIC] = tap_rise;
    assign events[`RTCIRQ_SRC_ALARM]    = alarm_event;
    assign events[`RTCIRQ_SRC_UPDATE]   = update_done_event;

    // Set wins over the read clear, so an event during a read survives it
    generate
        for (genvar k = 0; k < 3; k++) begin : g_flag
            assign flags_nxt[k] = (flags_r[k] && !flags_clear) ||
                                  events[k];
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    flags_r[k] <= 1'b0;
                end else begin
                    flags_r[k] <= flags_nxt[k];
                end
            end
        end
    endgenerate

    // Built from next values so the pin tracks flags and enables exactly
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= !(|(flags_nxt & irq_enable_nxt));
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sqw_r <= 1'b0;
        end else begin
            sqw_r <= square_wave_enable_r && tap_level;
        end
    end

    // Memory stays open during updates; no update gating on this path
    always_ff @(posedge clk) begin
        if (wr_do && wr_lane && wr_sel == RTCIRQ_SEL_MEM) begin
            nvram_mem[rtcirq_mem_idx(aw_addr_r)] <= w_data_r[7:0];
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_sel)
            RTCIRQ_SEL_CTRL_A: begin
                rd_word[`RTCIRQ_A_OSC_HI:`RTCIRQ_A_OSC_LO]   = osc_ctrl_r;
                rd_word[`RTCIRQ_A_RATE_HI:`RTCIRQ_A_RATE_LO] = rate_sel_r;
            end
            RTCIRQ_SEL_CTRL_B: begin
                rd_word[`RTCIRQ_B_EN_HI:`RTCIRQ_B_EN_LO] = irq_enable_r;
                rd_word[`RTCIRQ_B_SQUARE_WAVE_ENABLE] = square_wave_enable_r;
            end
            RTCIRQ_SEL_FLAGS: begin
                rd_word[`RTCIRQ_F_SUMMARY] = !irq_n_r;
                rd_word[`RTCIRQ_F_HI:`RTCIRQ_F_LO] = flags_r;
            end
            RTCIRQ_SEL_MEM: begin
                rd_word[7:0] = nvram_mem[rtcirq_mem_idx(s_axi_araddr)];
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // Read data is captured once and held, so flags cannot shift under it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_st_r   <= RTCIRQ_ST_IDLE;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= `RTCIRQ_RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else begin
            case (rd_st_r)
                RTCIRQ_ST_IDLE: begin
                    if (ar_fire) begin
                        rd_st_r   <= RTCIRQ_ST_RESP;
                        arready_r <= 1'b0;
                        rvalid_r  <= 1'b1;
                        rdata_r   <= rd_word;
                        rresp_r   <= (rd_sel == RTCIRQ_SEL_NONE) ?
                                     `RTCIRQ_RESP_SLVERR : `RTCIRQ_RESP_OKAY;
                    end else begin
                        arready_r <= 1'b1;
                    end
                end
                RTCIRQ_ST_RESP: begin
                    if (r_fire) begin
                        rd_st_r   <= RTCIRQ_ST_IDLE;
                        rvalid_r  <= 1'b0;
                        arready_r <= 1'b1;
                    end
                end
                default: begin
                    rd_st_r  <= RTCIRQ_ST_IDLE;
                    rvalid_r <= 1'b0;
                end
            endcase
        end
    end

    rtcirq_div u_div (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .osc_ctrl  (osc_ctrl_r),
        .rate_sel  (rate_sel_r),
        .tap_level (tap_level),
        .tap_rise  (tap_rise)
    );

    assign irq_n           = irq_n_r;
    assign square_wave_out = sqw_r;
    assign s_axi_awready   = awready_r;
    assign s_axi_wready    = wready_r;
    assign s_axi_bvalid    = bvalid_r;
    assign s_axi_bresp     = bresp_r;
    assign s_axi_arready   = arready_r;
    assign s_axi_rvalid    = rvalid_r;
    assign s_axi_rresp     = rresp_r;
    assign s_axi_rdata     = rdata_r;

    default clocking top_cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence seq_flag_read;
        flags_clear && events == 3'h0;
    endsequence

    sequence seq_enable_write;
        wr_do && wr_lane && wr_sel == RTCIRQ_SEL_CTRL_B &&
        |(w_data_r[`RTCIRQ_B_EN_HI:`RTCIRQ_B_EN_LO] & flags_r);
    endsequence

    irq_level_a: assert property (
            irq_n_r == !(|(flags_r & irq_enable_r)))
        else $error("request pin disagrees with flags and enables");
    irq_disabled_a: assert property (
            irq_enable_r == 3'h0 |-> irq_n_r)
        else $error("request asserted with all sources disabled");
    flag_poll_a: assert property (
            alarm_event |=> flags_r[`RTCIRQ_SRC_ALARM])
        else $error("alarm event did not set its flag");
    flag_clear_a: assert property (
            seq_flag_read |=> flags_r == 3'h0 && irq_n_r)
        else $error("flag read did not clear flags");
    read_event_a: assert property ((flags_clear && update_done_event)
            |=> flags_r[`RTCIRQ_SRC_UPDATE])
        else $error("event during flag read was lost");
    enable_pend_a: assert property (seq_enable_write ##1 1'b1
            |-> !irq_n_r)
        else $error("enabling a set flag did not assert request");
    summary_bit_a: assert property (flags_clear
            |=> s_axi_rdata[`RTCIRQ_F_SUMMARY] == !$past(irq_n_r) &&
                s_axi_rdata[3:0] == 4'h0)
        else $error("summary bit does not mirror request pin");
    read_stable_a: assert property ((rvalid_r && !s_axi_rready)
            |=> $stable(rdata_r) && rvalid_r)
        else $error("read data changed before it was taken");
    sqw_off_a: assert property (!square_wave_enable_r |=> !sqw_r)
        else $error("square wave active while disabled");
    periodic_set_a: assert property (tap_rise
            |=> flags_r[`RTCIRQ_SRC_PERIODIC])
        else $error("tap edge did not set periodic flag");

endmodule // rtcirq_top

`default_nettype wire

/* rtl/rtcirq_regs.svh */
// Register offsets, field positions, reset values and timing counts of
// the interrupt and rate-select block. Assumes a 20 MHz system clock.
`ifndef RTCIRQ_REGS_SVH
`define RTCIRQ_REGS_SVH

`define RTCIRQ_ADDR_W        12
`define RTCIRQ_OFF_CTRL_A    12'h000
`define RTCIRQ_OFF_CTRL_B    12'h004
`define RTCIRQ_OFF_FLAGS     12'h008
`define RTCIRQ_OFF_MEM       12'h100
`define RTCIRQ_MEM_BYTES     114
`define RTCIRQ_MEM_LAST      7'h71
`define RTCIRQ_MEM_IDX_HI    8
`define RTCIRQ_MEM_IDX_LO    2
`define RTCIRQ_OFF_MEM_END   12'h2C4
`define RTCIRQ_MEM_BASE_IDX  7'h40

`define RTCIRQ_A_OSC_HI      6
`define RTCIRQ_A_OSC_LO      4
`define RTCIRQ_A_RATE_HI     3
`define RTCIRQ_A_RATE_LO     0
`define RTCIRQ_B_EN_HI       6
`define RTCIRQ_B_EN_LO       4
`define RTCIRQ_B_SQUARE_WAVE_ENABLE        3
`define RTCIRQ_F_SUMMARY     7
`define RTCIRQ_F_HI          6
`define RTCIRQ_F_LO          4

`define RTCIRQ_SRC_PERIODIC  2
`define RTCIRQ_SRC_ALARM     1
`define RTCIRQ_SRC_UPDATE    0

`define RTCIRQ_RST_OSC       3'h0
`define RTCIRQ_RST_RATE      4'h0
`define RTCIRQ_RST_EN        3'h0
`define RTCIRQ_OSC_RUN       3'h2
`define RTCIRQ_OSC_HOLD      2'h3

`define RTCIRQ_RATE_OFF      4'h0
`define RTCIRQ_RATE_256      4'h1
`define RTCIRQ_RATE_128      4'h2
`define RTCIRQ_TAP_256       4'h6
`define RTCIRQ_TAP_128       4'h7
`define RTCIRQ_TAP_OFFSET    4'h2

`define RTCIRQ_CLK_PERIOD_NS 50
`define RTCIRQ_CLK_HZ        25'h1312D00
`define RTCIRQ_TIMEBASE_HZ   25'h0008000

`define RTCIRQ_RESP_OKAY     2'h0
`define RTCIRQ_RESP_SLVERR   2'h2

`endif

/* rtl/rtcirq_pkg.sv */
// Types shared by the interrupt and rate-select block.
// Assumes the constants header is included by each user.
package rtcirq_pkg;

    typedef enum logic [1:0] {
        RTCIRQ_ST_IDLE = 2'h1,
        RTCIRQ_ST_RESP = 2'h2
    } rtcirq_state_type;

    typedef enum logic [2:0] {
        RTCIRQ_SEL_NONE,
        RTCIRQ_SEL_CTRL_A,
        RTCIRQ_SEL_CTRL_B,
        RTCIRQ_SEL_FLAGS,
        RTCIRQ_SEL_MEM
    } rtcirq_sel_type;

endpackage

/* rtl/rtcirq_div.sv */
// Timebase tick, 15-stage divider chain and tap multiplexer.
// Assumes oscillator control and rate select come from flops in clk.
`timescale 1ns/1ps
`default_nettype none
`include "rtcirq_regs.svh"

module rtcirq_div
    import rtcirq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] osc_ctrl,
    input  wire logic [3:0] rate_sel,
    output logic            tap_level,
    output logic            tap_rise
);

    logic [24:0] phase_r;
    logic [24:0] phase_sum;
    logic        tick_r;
    logic [14:0] chain_r;
    logic        osc_on;
    logic        chain_run;
    logic        chain_hold;
    logic        tap_now;
    logic        tap_level_r;
    logic        tap_rise_r;

    // Returns the chain bit for a rate code, bit 4 set when none
    function automatic logic [4:0] rtcirq_tap(input logic [3:0] rs);
        if (rs == `RTCIRQ_RATE_OFF) begin
            return {1'b1, 4'h0};
        end else if (rs == `RTCIRQ_RATE_256) begin
            return {1'b0, `RTCIRQ_TAP_256};
        end else if (rs == `RTCIRQ_RATE_128) begin
            return {1'b0, `RTCIRQ_TAP_128};
        end else begin
            return {1'b0, rs - `RTCIRQ_TAP_OFFSET};
        end
    endfunction

    assign chain_hold = (osc_ctrl[2:1] == `RTCIRQ_OSC_HOLD);
    assign chain_run  = (osc_ctrl == `RTCIRQ_OSC_RUN);
    assign osc_on     = chain_run | chain_hold;
    assign phase_sum  = phase_r + `RTCIRQ_TIMEBASE_HZ;

    // Fractional accumulator gives a 32.768 kHz mean tick without a PLL
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_r <= 25'h0;
            tick_r  <= 1'b0;
        end else if (!osc_on) begin
            tick_r <= 1'b0;
        end else if (phase_sum >= `RTCIRQ_CLK_HZ) begin
            phase_r <= phase_sum - `RTCIRQ_CLK_HZ;
            tick_r  <= 1'b1;
        end else begin
            phase_r <= phase_sum;
            tick_r  <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || chain_hold) begin
            chain_r <= 15'h0;
        end else if (tick_r && chain_run) begin
            chain_r <= chain_r + 15'h1;
        end
    end

    always_comb begin
        logic [4:0] sel;
        sel     = rtcirq_tap(rate_sel);
        tap_now = !sel[4] && chain_r[sel[3:0]];
    end

    // A rate change may produce one extra edge; accepted as harmless
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tap_level_r <= 1'b0;
            tap_rise_r  <= 1'b0;
        end else begin
            tap_level_r <= tap_now;
            tap_rise_r  <= tap_now && !tap_level_r;
        end
    end

    assign tap_level = tap_level_r;
    assign tap_rise  = tap_rise_r;

    default clocking div_cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    hold_chain_a: assert property (chain_hold |=> chain_r == 15'h0)
        else $error("divider chain not held in reset");
    run_chain_a: assert property ((chain_run && tick_r)
            |=> chain_r == $past(chain_r) + 15'h1)
        else $error("divider chain did not advance on tick");
    osc_stop_a: assert property (!osc_on |=> !tick_r)
        else $error("timebase ticked with oscillator off");
    tick_pulse_a: assert property (tick_r |=> !tick_r)
        else $error("timebase tick longer than one cycle");
    no_rate_a: assert property ((rate_sel == `RTCIRQ_RATE_OFF)
            |=> !tap_level_r)
        else $error("tap active with rate disabled");

endmodule // rtcirq_div

`default_nettype wire

/* testbench/rtcirq_evt_src.sv */
// Far-side event source: alarm matcher and update sequencer stand-in.
// Assumes the bench raises req bits for one cycle per wanted event.
`timescale 1ns/1ps
`default_nettype none

module rtcirq_evt_src (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [1:0] req,
    output logic            alarm_event,
    output logic            update_done_event
);
    // Registered so every event is a clean one-cycle pulse in clk
    always_ff @(posedge clk) begin
        alarm_event       <= !sys_rst && req[1];
        update_done_event <= !sys_rst && req[0];
    end
endmodule // rtcirq_evt_src

`default_nettype wire

/* testbench/tb_rtc_interrupt_rate_select.sv */
// Self-checking bench of the interrupt and rate-select block.
// Assumes an AXI4-Lite master in this bench and the event source model.
`timescale 1ns/1ps
`default_nettype none
`include "rtcirq_regs.svh"

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    n_errors++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module tb_rtc_interrupt_rate_select;
    import rtcirq_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, irq_n, square_wave_out;
    logic alarm_event, update_done_event;
    logic [1:0] req = 2'h0, s_axi_bresp, s_axi_rresp;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] r;
    int n_errors = 0, n_checks = 0, cyc = 0, n;

    rtcirq_top rtcirq_top_inst (.clk(clk), .sys_rst(sys_rst),
        .alarm_event(alarm_event), .update_done_event(update_done_event),
        .irq_n(irq_n), .square_wave_out(square_wave_out),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    rtcirq_evt_src rtcirq_evt_src_inst (.clk(clk), .sys_rst(sys_rst),
        .req(req), .alarm_event(alarm_event),
        .update_done_event(update_done_event));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Longest test waits a few chain periods of about 2441 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic got;
        got = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!got) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                got = 1'b1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask

    task automatic rd(input logic [11:0] a);
        logic got;
        got = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                got = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
    endtask

    task automatic fire(input logic [1:0] which);
        @(posedge clk);
        req <= which;
        @(posedge clk);
        req <= 2'h0;
        repeat (3) @(posedge clk);
    endtask

    // Counts cycles until the square wave reaches level v, capped
    task automatic wait_sqw(input logic v);
        n = 0;
        while (square_wave_out !== v && n < 6000) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic t_reset;
        `CHK("irq_n", 1'b1, irq_n)
        `CHK("sqw", 1'b0, square_wave_out)
        rd(`RTCIRQ_OFF_CTRL_A);
        `CHK("ctrl_a", 32'h0, d)
        rd(`RTCIRQ_OFF_FLAGS);
        `CHK("flags", 32'h0, d)
        $display("test reset done");
    endtask

    task automatic t_poll;
        fire(2'h2);
        `CHK("irq_n", 1'b1, irq_n)
        rd(`RTCIRQ_OFF_FLAGS);
        `CHK("flags", 32'h20, d)
        rd(`RTCIRQ_OFF_FLAGS);
        `CHK("flags", 32'h0, d)
        // Update pulse lands on the clearing read edge and must survive it
        @(posedge clk);
        req <= 2'h1;
        fork
            rd(`RTCIRQ_OFF_FLAGS);
            begin
                @(posedge clk);
                req <= 2'h0;
            end
        join
        `CHK("pre_clear", 32'h0, d)
        rd(`RTCIRQ_OFF_FLAGS);
        `CHK("held_evt", 32'h10, d)
        $display("test poll done");
    endtask

    task automatic t_stale;
        fire(2'h1);
        wr(`RTCIRQ_OFF_CTRL_B, 8'h10);
        `CHK("irq_n", 1'b0, irq_n)
        rd(`RTCIRQ_OFF_FLAGS);
        `CHK("flags", 32'h90, d)
        @(posedge clk);
        `CHK("irq_n", 1'b1, irq_n)
        wr(`RTCIRQ_OFF_CTRL_B, 8'h00);
        $display("test stale done");
    endtask

    task automatic t_periodic;
        wr(`RTCIRQ_OFF_CTRL_A, 8'h23);
        wr(`RTCIRQ_OFF_CTRL_B, 8'h08);
        wait_sqw(1'b1);
        wait_sqw(1'b0);
        // Rate 3 holds each level for two timebase ticks of 610 or 611 cycles
        wait_sqw(1'b1);
        `CHK("sqw_half", 1'b1, n >= 1219 && n <= 1223)
        `CHK("irq_n", 1'b1, irq_n)
        rd(`RTCIRQ_OFF_FLAGS);
        `CHK("pf", 1'b1, d[6])
        wr(`RTCIRQ_OFF_CTRL_B, 8'h40);
        // Let the pin's last enabled sample retire before watching it
        @(posedge clk);
        n = 0;
        while (irq_n !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
            if (square_wave_out !== 1'b0) n = 9000;
        end
        `CHK("irq_wait", 1'b1, n < 3000)
        `CHK("sqw_off", 1'b0, square_wave_out)
        wr(`RTCIRQ_OFF_CTRL_A, 8'h63);
        rd(`RTCIRQ_OFF_FLAGS);
        repeat (3000) @(posedge clk);
        rd(`RTCIRQ_OFF_FLAGS);
        `CHK("held", 32'h0, d)
        $display("test periodic done");
    endtask

    task automatic t_bus;
        wr(`RTCIRQ_OFF_MEM, 8'hA5);
        `CHK("bresp", `RTCIRQ_RESP_OKAY, r)
        wr(12'h2C4, 8'h5A);
        `CHK("bresp", `RTCIRQ_RESP_OKAY, r)
        rd(`RTCIRQ_OFF_MEM);
        `CHK("mem_lo", 32'hA5, d)
        rd(12'h2C4);
        `CHK("mem", 32'h5A, d)
        `CHK("rresp", `RTCIRQ_RESP_OKAY, r)
        rd(12'h0FC);
        `CHK("resp", `RTCIRQ_RESP_SLVERR, r)
        $display("test bus done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_poll();
        t_stale();
        t_periodic();
        t_bus();
        report_and_stop();
    end
endmodule // tb_rtc_interrupt_rate_select

`default_nettype wire
